// File: logic/trsc_cfg.svh
`ifndef TRSC_CFG_SVH
`define TRSC_CFG_SVH
// register byte offsets
`define TRSC_OFS_CTRL    8'h00
`define TRSC_OFS_STAGE   8'h04
`define TRSC_OFS_NEXT    8'h08
`define TRSC_OFS_OWN     8'h0C
`define TRSC_OFS_STATUS  8'h10
// network_control_one bit positions
`define TRSC_B_UPDATE    0
`define TRSC_B_TIMERS_DISABLE      1
`define TRSC_B_GETRING   3
`define TRSC_B_ADDRESS_DRIVE_ENABLE      4
`define TRSC_B_INIT      5
`define TRSC_B_PIGGY     6
`define TRSC_B_DIAG      7
// bit 2 is reserved and reads zero
`define TRSC_CTRL_MASK   8'hFB
`define TRSC_CTRL_RESET  8'h00
`define TRSC_STAGE_RESET 8'h01
`define TRSC_OWN_RESET   8'h01
// valid node address range
`define TRSC_ADDR_MIN    8'h01
`define TRSC_ADDR_MAX    8'hFE
`endif

// File: logic/trsc_pkg.sv
package trsc_pkg;
   // scan sequencer states
   typedef enum logic [1:0] {
      TRSC_IDLE = 2'b00,
      TRSC_SEND = 2'b01,
      TRSC_WAIT = 2'b10
   } trsc_scan_t;
   typedef logic [7:0] trsc_node_t;
endpackage : trsc_pkg

// File: logic/trsc_top.sv
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "trsc_cfg.svh"

module trsc_top (
   // clock, reset, enable
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // dma address pins
   input  wire logic [15:0]      dma_addr,
   input  wire logic             dma_acknowledge_n,
   output logic      [15:0]      addr_out,
   output logic                  addr_oe,
   // ring events
   input  wire logic             net_active,
   input  wire logic             dead_timer_expired,
   input  wire logic             scan_frame_rx,
   input  wire logic             node_responded,
   input  wire trsc_pkg::trsc_node_t responder_addr,
   input  wire logic             pass_timeout,
   output logic                  tp_req,
   output trsc_pkg::trsc_node_t  tp_dest,
   // transmit end of burst
   input  wire logic             last_frame,
   input  wire logic             last_by_limit,
   input  wire logic             last_by_final,
   input  wire logic             last_by_chain_end,
   output logic                  piggyback_token
);
   import trsc_pkg::*;

   logic [7:0] ctrl_reg;
   trsc_node_t stage_reg;
   trsc_node_t next_reg;
   trsc_node_t own_reg;
   trsc_node_t dest_reg;
   trsc_node_t dest_next;
   trsc_scan_t state_reg;
   logic       net_prev_reg;
   logic [1:0] result_reg;
   logic       acc;
   logic       wr;
   logic       wr_ctrl;
   logic       net_entry;
   logic       timers_disable;
   logic       scan_start;
   logic       resp_hit;
   logic       step;

   // ascending circular successor within the valid range
   function automatic trsc_node_t trsc_inc(input trsc_node_t a);
      if (a >= `TRSC_ADDR_MAX || a < `TRSC_ADDR_MIN) begin
         return `TRSC_ADDR_MIN;
      end
      return trsc_node_t'(a + 8'h01);
   endfunction : trsc_inc

   // bus decode; a write lands in the cycle the ack is raised
   assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr      = acc && wb_we_i && wb_sel_i[0];
   assign wr_ctrl = wr && (wb_adr_i == `TRSC_OFS_CTRL);
   assign timers_disable    = ctrl_reg[`TRSC_B_TIMERS_DISABLE];
   assign net_entry = net_active && !net_prev_reg;

   // scan launches only from a live dead-timer expiry
   assign scan_start = (state_reg == TRSC_IDLE) && dead_timer_expired &&
                       ctrl_reg[`TRSC_B_INIT] &&
                       !timers_disable &&
                       !ctrl_reg[`TRSC_B_DIAG];
   assign resp_hit = (state_reg == TRSC_WAIT) && node_responded;
   // pass timeout is a protocol timer, so timers_disable masks it
   assign step      = (state_reg == TRSC_WAIT) && !node_responded &&
                      !scan_frame_rx && pass_timeout && !timers_disable;
   assign dest_next = trsc_inc(dest_reg);

   // single-cycle ack, dropped the cycle after
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= acc;
      end
   end

   // read mux, unmapped offsets read zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce && acc && !wb_we_i) begin
         unique case (wb_adr_i)
            `TRSC_OFS_CTRL:   wb_dat_o <= {24'h00_0000, ctrl_reg};
            `TRSC_OFS_STAGE:  wb_dat_o <= {24'h00_0000, stage_reg};
            `TRSC_OFS_NEXT:   wb_dat_o <= {24'h00_0000, next_reg};
            `TRSC_OFS_OWN:    wb_dat_o <= {24'h00_0000, own_reg};
            `TRSC_OFS_STATUS: wb_dat_o <= {26'h000_0000, result_reg,
                                           1'b0, state_reg, net_active};
            default:          wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // control register; a host set wins over the self-clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= `TRSC_CTRL_RESET;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_reg <= wb_dat_i[7:0] & `TRSC_CTRL_MASK;
         end else if (ctrl_reg[`TRSC_B_UPDATE]) begin
            ctrl_reg[`TRSC_B_UPDATE] <= 1'b0;
         end
      end
   end

   // staging register for the host-defined successor
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_reg <= `TRSC_STAGE_RESET;
      end else if (ce && wr && wb_adr_i == `TRSC_OFS_STAGE) begin
         stage_reg <= wb_dat_i[7:0];
      end
   end

   // own address is frozen while the ring is live
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         own_reg <= `TRSC_OWN_RESET;
      end else if (ce && wr && wb_adr_i == `TRSC_OFS_OWN && !net_active) begin
         own_reg <= wb_dat_i[7:0];
      end
   end

   // edge detect for entry into network state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         net_prev_reg <= 1'b0;
      end else if (ce) begin
         net_prev_reg <= net_active;
      end
   end

   // successor; ring-wide events outrank a host update
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         next_reg <= `TRSC_STAGE_RESET;
      end else if (ce) begin
         if (net_entry) begin
            next_reg <= trsc_inc(own_reg);
         end else if (scan_frame_rx) begin
            next_reg <= trsc_inc(own_reg);
         end else if (resp_hit) begin
            next_reg <= responder_addr;
         end else if (ctrl_reg[`TRSC_B_UPDATE]) begin
            next_reg <= stage_reg;
         end
      end
   end

   // scan sequencer: one token pass at a time, upward
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg  <= TRSC_IDLE;
         dest_reg   <= `TRSC_STAGE_RESET;
         result_reg <= 2'b00;
      end else if (ce) begin
         unique case (state_reg)
            TRSC_IDLE: begin
               if (scan_start) begin
                  state_reg  <= TRSC_SEND;
                  dest_reg   <= next_reg;
                  result_reg <= 2'b00;
               end
            end
            TRSC_SEND: begin
               state_reg <= TRSC_WAIT;
            end
            TRSC_WAIT: begin
               if (resp_hit || scan_frame_rx) begin
                  state_reg  <= TRSC_IDLE;
                  result_reg <= 2'b01;
               end else if (step && dest_next == own_reg) begin
                  state_reg  <= TRSC_IDLE;
                  result_reg <= 2'b10;
               end else if (step) begin
                  state_reg <= TRSC_SEND;
                  dest_reg  <= dest_next;
               end
            end
            default: begin
               state_reg <= TRSC_IDLE;
            end
         endcase
      end
   end

   // token pass request, one cycle per destination
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tp_req  <= 1'b0;
         tp_dest <= 8'h00;
      end else if (ce) begin
         tp_req  <= (state_reg == TRSC_SEND);
         tp_dest <= dest_reg;
      end
   end

   // address pins; dma_acknowledge_n forces drive even when disabled
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_out <= 16'h0000;
         addr_oe  <= 1'b0;
      end else if (ce) begin
         addr_out <= dma_addr;
         addr_oe  <= ctrl_reg[`TRSC_B_ADDRESS_DRIVE_ENABLE] ||
                     !dma_acknowledge_n;
      end
   end

   // piggyback only when the last frame was chosen, not exhausted
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         piggyback_token <= 1'b0;
      end else if (ce) begin
         piggyback_token <= last_frame && ctrl_reg[`TRSC_B_PIGGY] &&
                            (last_by_limit || last_by_final) &&
                            !last_by_chain_end;
      end
   end

   // checks
   property p_addr_float;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && !ctrl_reg[`TRSC_B_ADDRESS_DRIVE_ENABLE] && dma_acknowledge_n |=> !addr_oe;
   endproperty
   a_addr_float: assert property (p_addr_float)
      else $error("address pins driven while disabled");

   property p_addr_drive;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && ctrl_reg[`TRSC_B_ADDRESS_DRIVE_ENABLE] |=> addr_oe && addr_out == $past(dma_addr);
   endproperty
   a_addr_drive: assert property (p_addr_drive)
      else $error("address pins released while enabled");

   property p_no_reinit;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && state_reg == TRSC_IDLE &&
      (!ctrl_reg[`TRSC_B_INIT] || timers_disable) |=> state_reg == TRSC_IDLE;
   endproperty
   a_no_reinit: assert property (p_no_reinit)
      else $error("scan began without permission");

   sequence s_launch;
      ce && scan_start;
   endsequence
   sequence s_first_pass(trsc_node_t d);
      state_reg == TRSC_SEND && dest_reg == d && ce ##1 tp_req && tp_dest == d;
   endsequence
   property p_scan_start;
      trsc_node_t d;
      @(posedge ref_clk) disable iff (!rst_b)
      (s_launch, d = next_reg) |=> s_first_pass(d);
   endproperty
   a_scan_start: assert property (p_scan_start)
      else $error("scan did not start at successor");

   property p_entry_na;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && net_entry |=> next_reg == trsc_inc($past(own_reg));
   endproperty
   a_entry_na: assert property (p_entry_na)
      else $error("successor not own plus one on entry");

   property p_update;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && ctrl_reg[`TRSC_B_UPDATE] && !net_entry && !scan_frame_rx &&
      !resp_hit && !wr_ctrl |=> next_reg == $past(stage_reg) &&
      !ctrl_reg[`TRSC_B_UPDATE];
   endproperty
   a_update: assert property (p_update)
      else $error("staged successor not adopted");

   property p_rx_na;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && scan_frame_rx && !net_entry |=> next_reg == trsc_inc($past(own_reg));
   endproperty
   a_rx_na: assert property (p_rx_na)
      else $error("scan frame did not reset successor");

   property p_resp_na;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && resp_hit && !net_entry && !scan_frame_rx |=>
      next_reg == $past(responder_addr) && state_reg == TRSC_IDLE;
   endproperty
   a_resp_na: assert property (p_resp_na)
      else $error("responder not taken as successor");

   property p_advance;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && step |=> (state_reg == TRSC_IDLE && $past(dest_next) == own_reg) ||
      (state_reg == TRSC_SEND && dest_reg == trsc_inc($past(dest_reg)));
   endproperty
   a_advance: assert property (p_advance)
      else $error("scan step wrong");

   property p_piggy;
      @(posedge ref_clk) disable iff (!rst_b)
      ce && last_frame && last_by_chain_end |=> !piggyback_token;
   endproperty
   a_piggy: assert property (p_piggy)
      else $error("token piggybacked on chain end");
endmodule : trsc_top

// File: tb/tb_top.sv
`timescale 1ns/100ps
`include "trsc_cfg.svh"
module tb_top;
   import trsc_pkg::*;
   logic ref_clk, rst_b, cyc, stb, we, ack, dma_acknowledge_n_n, oe, act, dte, sfr, resp, pto, tp, lf, lim, fin, che, pig;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat;
   logic [15:0] dma, aout;
   trsc_node_t  raddr, dest, live;
   trsc_node_t  dq[$];
   int          miscompares = 0, cmp_count = 0, pig_cnt = 0;
   trsc_top trsc_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .dma_addr(dma), .dma_acknowledge_n(dma_acknowledge_n_n), .addr_out(aout), .addr_oe(oe), .net_active(act),
      .dead_timer_expired(dte), .scan_frame_rx(sfr), .node_responded(resp), .responder_addr(raddr),
      .pass_timeout(pto), .tp_req(tp), .tp_dest(dest), .last_frame(lf), .last_by_limit(lim),
      .last_by_final(fin), .last_by_chain_end(che), .piggyback_token(pig));
   trsc_ring_model trsc_ring_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .tp_req(tp), .tp_dest(dest),
      .live_addr(live), .node_responded(resp), .responder_addr(raddr), .pass_timeout(pto));
   // clock at 50 MHz
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // log every token pass and every piggy-back pulse
   always @(posedge ref_clk) begin
      if (tp === 1'b1) dq.push_back(dest);
      if (pig === 1'b1) pig_cnt++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // classic single cycle; waits for ack, then one idle cycle follows
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1, "no ack");
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, {24'h000000, e}, m);
   endtask : rd
   // pulse one event input (0 dead timer, 1 scan frame, 2 last frame) for one cycle, then let the block settle
   task automatic pulse(input int k, input int c);
      @(posedge ref_clk);
      if (k == 0) dte <= 1'b1;
      else if (k == 1) sfr <= 1'b1;
      else lf <= 1'b1;
      @(posedge ref_clk);
      {dte, sfr, lf} <= 3'b000;
      repeat (c) @(posedge ref_clk);
   endtask : pulse
   task automatic t_reset;
      rd(`TRSC_OFS_CTRL, 8'h00, "ctrl reset");
      rd(`TRSC_OFS_NEXT, 8'h01, "next reset");
      rd(`TRSC_OFS_OWN, 8'h01, "own reset");
      rd(8'h40, 8'h00, "unmapped read");
   endtask : t_reset
   task automatic t_pins;
      wr(`TRSC_OFS_CTRL, 8'h00);
      repeat (3) @(posedge ref_clk);
      chk(oe, 1'b0, "pins float");
      dma_acknowledge_n_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({oe, aout}, {1'b1, dma}, "dma ack drives");
      dma_acknowledge_n_n <= 1'b1;
      wr(`TRSC_OFS_CTRL, 8'h10);
      repeat (3) @(posedge ref_clk);
      chk(oe, 1'b1, "always driven");
   endtask : t_pins
   task automatic t_succ;
      wr(`TRSC_OFS_OWN, 8'h05);
      act <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(`TRSC_OFS_NEXT, 8'h06, "entry own+1");
      wr(`TRSC_OFS_OWN, 8'h09);
      rd(`TRSC_OFS_OWN, 8'h05, "own held");
      wr(`TRSC_OFS_STAGE, 8'hFE);
      wr(`TRSC_OFS_CTRL, 8'h01);
      rd(`TRSC_OFS_NEXT, 8'hFE, "staged copy");
      rd(`TRSC_OFS_CTRL, 8'h00, "update self-clears");
   endtask : t_succ
   task automatic t_scan(input logic [7:0] c, input trsc_node_t l, input int n, input trsc_node_t e);
      dq.delete();
      live <= l;
      wr(`TRSC_OFS_CTRL, c);
      pulse(0, 60);
      chk(dq.size(), n, "pass count");
      if (n > 0) chk(dq[0], 8'hFE, "first dest");
      if (n == 3) chk({dq[1], dq[2]}, 16'h0102, "wrap order");
      rd(`TRSC_OFS_NEXT, e, "successor after scan");
   endtask : t_scan
   task automatic t_piggy;
      logic [3:0] tbl[5] = '{4'hC, 4'hA, 4'h9, 4'h8, 4'h4};
      for (int i = 0; i < 5; i++) begin
         wr(`TRSC_OFS_CTRL, {1'b0, tbl[i][3], 6'h00});
         pig_cnt = 0;
         lim <= tbl[i][2];
         fin <= tbl[i][1];
         che <= tbl[i][0];
         pulse(2, 3);
         chk(pig_cnt, i < 2, "piggy-back pulse");
      end
   endtask : t_piggy
   task automatic print_verdict;
      $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      {rst_b, cyc, stb, we, dte, sfr, act, lf, lim, fin, che} = '0;
      {adr, wdat, live} = '0;
      dma_acknowledge_n_n = 1'b1;
      dma = 16'hA5C3;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_pins();
      t_succ();
      t_scan(8'h00, 8'h02, 0, 8'hFE);
      t_scan(8'h22, 8'h02, 0, 8'hFE);
      t_scan(8'h20, 8'h02, 3, 8'h02);
      rd(`TRSC_OFS_STATUS, 8'h11, "scan ended on response");
      pulse(1, 3);
      rd(`TRSC_OFS_NEXT, 8'h06, "scan frame own+1");
      wr(`TRSC_OFS_STAGE, 8'hFE);
      wr(`TRSC_OFS_CTRL, 8'h21);
      t_scan(8'h20, 8'h00, 5, 8'hFE);
      rd(`TRSC_OFS_STATUS, 8'h21, "scan stopped at own");
      t_piggy();
      print_verdict();
   end
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule : tb_top

// File: tb/trsc_ring_model.sv
`timescale 1ns/100ps
// far-side ring nodes: one live node answers a token pass, the rest stay silent
module trsc_ring_model (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   // token pass from the block, live node address from the testbench
   input  wire logic                 tp_req,
   input  wire trsc_pkg::trsc_node_t tp_dest,
   input  wire trsc_pkg::trsc_node_t live_addr,
   // answers back to the block
   output logic                      node_responded,
   output trsc_pkg::trsc_node_t      responder_addr,
   output logic                      pass_timeout
);
   import trsc_pkg::*;
   logic [1:0] wait_reg;
   trsc_node_t dest_reg;
   // answer three cycles after the pass; silence becomes a timeout pulse
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_reg       <= 2'h0;
         dest_reg       <= 8'h00;
         node_responded <= 1'b0;
         pass_timeout   <= 1'b0;
         responder_addr <= 8'h00;
      end else begin
         node_responded <= 1'b0;
         pass_timeout   <= 1'b0;
         responder_addr <= ~responder_addr; // inverted every cycle outside an answer
         if (tp_req) begin
            wait_reg <= 2'h3;
            dest_reg <= tp_dest;
         end else if (wait_reg == 2'h1) begin
            wait_reg <= 2'h0;
            if (dest_reg == live_addr) begin
               node_responded <= 1'b1;
               responder_addr <= dest_reg;
            end else begin
               pass_timeout <= 1'b1;
            end
         end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
         end
      end
   end
endmodule : trsc_ring_model
